// ===== inc/emstat_pkg.sv
package emstat_pkg;

  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int N_FRAMES = 4;
  localparam int SEL_W = 2;

  typedef logic [ADDR_W-1:0] emstat_addr_t;

  // Register byte offsets
  localparam emstat_addr_t OFF_WAKE_MASK = 8'h8c;
  localparam emstat_addr_t OFF_NORMAL_TX_PTR = 8'h90;
  localparam emstat_addr_t OFF_HIGH_TX_PTR = 8'h94;
  localparam emstat_addr_t OFF_RX_PTR = 8'h98;
  localparam emstat_addr_t OFF_TX_GOOD = 8'ha0;
  localparam emstat_addr_t OFF_TX_COL_OK = 8'ha4;
  localparam emstat_addr_t OFF_TX_FAIL = 8'ha8;
  localparam emstat_addr_t OFF_TX_UNDER_LATE = 8'hac;
  localparam emstat_addr_t OFF_RX_GOOD = 8'hb0;
  localparam emstat_addr_t OFF_RX_BCAST = 8'hb4;
  localparam emstat_addr_t OFF_RX_MCAST = 8'hb8;
  localparam emstat_addr_t OFF_RX_PAUSE_ALIGN = 8'hbc;
  localparam emstat_addr_t OFF_RX_RUNT = 8'hc0;
  localparam emstat_addr_t OFF_WAKE_CTRL = 8'hd0;

  // Field positions
  localparam int WAKE_SEL_LSB = 0;
  localparam int HALF_W = 16;
  localparam int UPPER_LSB = 16;

  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [1:0] RST_SEL = 2'h0;
  localparam logic RST_WAIT = 1'b1;

  // Counter slots; the first N_WIDE are 32 bits, the rest 16 bits
  localparam int CNT_TX_GOOD = 0;
  localparam int CNT_RX_GOOD = 1;
  localparam int CNT_RX_BCAST = 2;
  localparam int CNT_RX_MCAST = 3;
  localparam int CNT_TX_MULTI = 4;
  localparam int CNT_TX_SINGLE = 5;
  localparam int CNT_TX_ANY_FAIL = 6;
  localparam int CNT_TX_EXCESS = 7;
  localparam int CNT_TX_UNDERRUN = 8;
  localparam int CNT_TX_LATE = 9;
  localparam int CNT_RX_PAUSE = 10;
  localparam int CNT_RX_ALIGN = 11;
  localparam int CNT_RX_RUNT = 12;
  localparam int N_CNT = 13;
  localparam int N_WIDE = 4;

  // One-cycle outcome pulses from the transmit and receive paths
  typedef struct packed {
    logic rx_runt;
    logic rx_align_err;
    logic rx_pause;
    logic tx_late_col;
    logic tx_underrun;
    logic tx_excess_col;
    logic tx_single_col;
    logic tx_multi_col;
    logic rx_mcast;
    logic rx_bcast;
    logic rx_good;
    logic tx_good;
  } emstat_evt_t;

  // Live descriptor pointers of the three rings
  typedef struct packed {
    logic [31:0] normal_tx;
    logic [31:0] high_tx;
    logic [31:0] rx;
  } emstat_ring_t;

endpackage

// ===== rtl/emstat_counter.sv
`timescale 1ns/1ps
module emstat_counter #(
  parameter int W = 32
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic inc,
  output logic [31:0] count
);

  localparam logic [63:0] ONE64 = 64'h1;
  localparam logic [31:0] MAX = 32'((ONE64 << W) - ONE64);

  logic [31:0] count_q;
  logic [31:0] count_d;

  // Wrap to zero past the top value, never saturate
  assign count_d = (count_q == MAX) ? emstat_pkg::RST_ZERO : count_q + 32'h1;

  // Count one per event pulse
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= emstat_pkg::RST_ZERO;
    end else if (inc) begin
      count_q <= count_d;
    end
  end

  assign count = count_q;

endmodule // emstat_counter

// ===== rtl/emstat_top.sv
// How it works
// - Fourth mask word bit 0 enables frame byte 97, bit 31 byte 128.
// - Frame select 00..11 picks which of four mask copies is read or written.
// - Offset 0x90 reads the normal transmit ring's current descriptor pointer.
// - Offset 0x94 reads the high transmit ring's current descriptor pointer.
// - A read-only register shows the receive ring's current descriptor pointer.
// - Offset 0xa0 counts packets sent successfully, 32 bits.
// - Upper half of 0xa4 counts packets sent after 2 to 15 collisions.
// - Lower half of 0xa4 counts packets sent after exactly one collision.
// - Upper half of 0xa8 counts late, excess collision and underrun failures.
// - Lower half of 0xa8 counts failures from 16 or more collisions.
// - Upper half of 0xac counts packets aborted by transmit underrun.
// - Lower half of 0xac counts packets failed by late collision.
// - A 32-bit counter counts packets received without error.
// - Offset 0xb4 counts received broadcast packets.
// - Offset 0xb8 counts received multicast packets.
// - Upper half of 0xbc counts received pause frames.
// - Lower half of 0xbc counts CRC-bad frames not ending on a byte.
// - Lower half of 0xc0 counts runt frames; upper half reads zero.
`timescale 1ns/1ps
module emstat_top (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [emstat_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire emstat_pkg::emstat_evt_t mac_events,
  input wire emstat_pkg::emstat_ring_t ring_pointers,
  output logic [1:0] wake_frame_select,
  output logic [emstat_pkg::N_FRAMES*32-1:0] wake_mask_words
);

  // Bus handshake state
  logic waitrequest_q;
  logic waitrequest_d;
  logic [31:0] readdata_q;
  logic [31:0] readdata_d;

  // Wake-up mask banks and their selector
  logic [1:0] wake_sel_q;
  logic [1:0] wake_sel_d;
  logic [31:0] wake_mask_q [emstat_pkg::N_FRAMES];

  // Sampled ring pointers and counter values
  emstat_pkg::emstat_ring_t ring_q;
  logic [31:0] cnt [emstat_pkg::N_CNT];
  logic [emstat_pkg::N_CNT-1:0] cnt_inc;

  // Request phases: accept on first cycle, complete on second
  wire req = read | write;
  wire accept = req & waitrequest_q;
  wire done = req & ~waitrequest_q;
  wire wr_done = done & write;

  // Address decode
  wire hit_mask = address == emstat_pkg::OFF_WAKE_MASK;
  wire hit_ctrl = address == emstat_pkg::OFF_WAKE_CTRL;
  wire hit_npt = address == emstat_pkg::OFF_NORMAL_TX_PTR;
  wire hit_hpt = address == emstat_pkg::OFF_HIGH_TX_PTR;
  wire hit_rpt = address == emstat_pkg::OFF_RX_PTR;
  wire hit_txg = address == emstat_pkg::OFF_TX_GOOD;
  wire hit_col = address == emstat_pkg::OFF_TX_COL_OK;
  wire hit_fail = address == emstat_pkg::OFF_TX_FAIL;
  wire hit_unl = address == emstat_pkg::OFF_TX_UNDER_LATE;
  wire hit_rxg = address == emstat_pkg::OFF_RX_GOOD;
  wire hit_bc = address == emstat_pkg::OFF_RX_BCAST;
  wire hit_mc = address == emstat_pkg::OFF_RX_MCAST;
  wire hit_pa = address == emstat_pkg::OFF_RX_PAUSE_ALIGN;
  wire hit_runt = address == emstat_pkg::OFF_RX_RUNT;

  // Byte-lane write mask from byteenable
  wire [31:0] be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                         {8{byteenable[1]}}, {8{byteenable[0]}}};

  // Bank chosen by the frame select
  wire [31:0] sel_bank = wake_mask_q[wake_sel_q];
  wire [31:0] mask_merged = (sel_bank & ~be_mask) | (writedata & be_mask);

  // Paired 16-bit counters packed into their words
  wire [31:0] col_word = {cnt[emstat_pkg::CNT_TX_MULTI][15:0],
                          cnt[emstat_pkg::CNT_TX_SINGLE][15:0]};
  wire [31:0] fail_word = {cnt[emstat_pkg::CNT_TX_ANY_FAIL][15:0],
                           cnt[emstat_pkg::CNT_TX_EXCESS][15:0]};
  wire [31:0] unl_word = {cnt[emstat_pkg::CNT_TX_UNDERRUN][15:0],
                          cnt[emstat_pkg::CNT_TX_LATE][15:0]};
  wire [31:0] pa_word = {cnt[emstat_pkg::CNT_RX_PAUSE][15:0],
                         cnt[emstat_pkg::CNT_RX_ALIGN][15:0]};
  wire [31:0] runt_word = {16'h0000, cnt[emstat_pkg::CNT_RX_RUNT][15:0]};
  wire [31:0] ctrl_word = {30'h0000_0000, wake_sel_q};

  // Read multiplexer; unmapped offsets read zero
  wire [31:0] rd_mux =
    hit_mask ? sel_bank :
    hit_ctrl ? ctrl_word :
    hit_npt ? ring_q.normal_tx :
    hit_hpt ? ring_q.high_tx :
    hit_rpt ? ring_q.rx :
    hit_txg ? cnt[emstat_pkg::CNT_TX_GOOD] :
    hit_col ? col_word :
    hit_fail ? fail_word :
    hit_unl ? unl_word :
    hit_rxg ? cnt[emstat_pkg::CNT_RX_GOOD] :
    hit_bc ? cnt[emstat_pkg::CNT_RX_BCAST] :
    hit_mc ? cnt[emstat_pkg::CNT_RX_MCAST] :
    hit_pa ? pa_word :
    hit_runt ? runt_word :
    emstat_pkg::RST_ZERO;

  // Next-state terms of the bus slave
  assign waitrequest_d = ~accept;
  assign readdata_d = (accept & read) ? rd_mux : readdata_q;
  assign wake_sel_d = (wr_done & hit_ctrl & byteenable[0]) ?
                      writedata[emstat_pkg::WAKE_SEL_LSB +: emstat_pkg::SEL_W] : wake_sel_q;

  // Bus answer registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      waitrequest_q <= emstat_pkg::RST_WAIT;
      readdata_q <= emstat_pkg::RST_ZERO;
    end else begin
      waitrequest_q <= waitrequest_d;
      readdata_q <= readdata_d;
    end
  end

  // Frame select register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wake_sel_q <= emstat_pkg::RST_SEL;
    end else begin
      wake_sel_q <= wake_sel_d;
    end
  end

  // Four mask copies; only the selected one takes a write
  for (genvar f = 0; f < emstat_pkg::N_FRAMES; f++) begin : g_bank
    wire bank_wr = wr_done & hit_mask & (wake_sel_q == 2'(f));
    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        wake_mask_q[f] <= emstat_pkg::RST_ZERO;
      end else if (bank_wr) begin
        wake_mask_q[f] <= mask_merged;
      end
    end
    assign wake_mask_words[f*32 +: 32] = wake_mask_q[f];
  end

  // Ring pointers follow the descriptor engines, read-only to software
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ring_q <= '0;
    end else begin
      ring_q <= ring_pointers;
    end
  end

  // Counter increments from the outcome pulses
  assign cnt_inc[emstat_pkg::CNT_TX_GOOD] = mac_events.tx_good;
  assign cnt_inc[emstat_pkg::CNT_TX_MULTI] = mac_events.tx_multi_col;
  assign cnt_inc[emstat_pkg::CNT_TX_SINGLE] = mac_events.tx_single_col;
  assign cnt_inc[emstat_pkg::CNT_TX_ANY_FAIL] = mac_events.tx_late_col |
                                                mac_events.tx_excess_col |
                                                mac_events.tx_underrun;
  assign cnt_inc[emstat_pkg::CNT_TX_EXCESS] = mac_events.tx_excess_col;
  assign cnt_inc[emstat_pkg::CNT_TX_UNDERRUN] = mac_events.tx_underrun;
  assign cnt_inc[emstat_pkg::CNT_TX_LATE] = mac_events.tx_late_col;
  assign cnt_inc[emstat_pkg::CNT_RX_GOOD] = mac_events.rx_good;
  assign cnt_inc[emstat_pkg::CNT_RX_BCAST] = mac_events.rx_bcast;
  assign cnt_inc[emstat_pkg::CNT_RX_MCAST] = mac_events.rx_mcast;
  assign cnt_inc[emstat_pkg::CNT_RX_PAUSE] = mac_events.rx_pause;
  assign cnt_inc[emstat_pkg::CNT_RX_ALIGN] = mac_events.rx_align_err;
  assign cnt_inc[emstat_pkg::CNT_RX_RUNT] = mac_events.rx_runt;

  // One counter per statistic; no write path reaches them
  for (genvar i = 0; i < emstat_pkg::N_CNT; i++) begin : g_cnt
    emstat_counter #(
      .W((i < emstat_pkg::N_WIDE) ? 32 : 16)
    ) u_cnt (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .inc(cnt_inc[i]),
      .count(cnt[i])
    );
  end

  // Outputs straight from flops
  assign readdata = readdata_q;
  assign waitrequest = waitrequest_q;
  assign wake_frame_select = wake_sel_q;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_accept;
    (read || write) && waitrequest_q;
  endsequence

  sequence s_rd(logic hit);
    read && waitrequest_q && hit;
  endsequence

  sequence s_full_mask_wr;
    write && !waitrequest_q && hit_mask && (byteenable == 4'hf);
  endsequence

  // Bus answers exactly one cycle after acceptance
  AST_BUS_ANSWER: assert property (s_accept |=> !waitrequest_q ##1 waitrequest_q)
    else $error("waitrequest not low for exactly one cycle");

  AST_MASK_WRITE: assert property (
    s_full_mask_wr |=> sel_bank == $past(writedata))
    else $error("mask word write lost");

  AST_MASK_BANK: assert property (
    s_rd(hit_mask) |=> readdata_q == wake_mask_q[$past(wake_sel_q)])
    else $error("mask read from wrong bank");

  AST_NORMAL_PTR: assert property (
    s_rd(hit_npt) |=> readdata_q == $past(ring_q.normal_tx))
    else $error("normal ring pointer read wrong");

  AST_HIGH_PTR: assert property (
    s_rd(hit_hpt) |=> readdata_q == $past(ring_q.high_tx))
    else $error("high ring pointer read wrong");

  AST_RX_PTR: assert property (
    s_rd(hit_rpt) |=> readdata_q == $past(ring_q.rx))
    else $error("receive ring pointer read wrong");

  AST_TX_GOOD: assert property (
    mac_events.tx_good |=> cnt[emstat_pkg::CNT_TX_GOOD] ==
      32'($past(cnt[emstat_pkg::CNT_TX_GOOD]) + 32'h1))
    else $error("good transmit count did not advance");

  AST_ANY_FAIL: assert property (
    mac_events.tx_underrun |=> cnt[emstat_pkg::CNT_TX_ANY_FAIL][15:0] ==
      16'($past(cnt[emstat_pkg::CNT_TX_ANY_FAIL][15:0]) + 16'h1))
    else $error("failure count missed an underrun");

  AST_EXCESS_ONLY: assert property (
    !mac_events.tx_excess_col |=> $stable(cnt[emstat_pkg::CNT_TX_EXCESS]))
    else $error("excess collision count moved without cause");

  AST_RUNT_UPPER: assert property (
    s_rd(hit_runt) |=> readdata_q[31:16] == 16'h0000)
    else $error("runt register upper half not zero");

  AST_RO_WRITE: assert property (
    write && hit_txg && !mac_events.tx_good |=> $stable(cnt[emstat_pkg::CNT_TX_GOOD]))
    else $error("software write changed a counter");

  AST_WRAP: assert property (
    mac_events.tx_single_col && cnt[emstat_pkg::CNT_TX_SINGLE] == 32'h0000_ffff
      |=> cnt[emstat_pkg::CNT_TX_SINGLE] == 32'h0000_0000)
    else $error("16-bit counter did not wrap");

endmodule // emstat_top

// ===== verification/emstat_mac_model.sv
`timescale 1ns/1ps
// Stand-in for the transmit and receive paths: outcome pulses and ring pointers
module emstat_mac_model (
  input wire logic clk_sys,
  output emstat_pkg::emstat_evt_t mac_events,
  output emstat_pkg::emstat_ring_t ring_pointers
);
  // Quiet paths until told otherwise
  initial begin
    mac_events = '0;
    ring_pointers = '0;
  end

  // Hold a set of outcome bits high for n cycles, so each bit counts n
  task automatic pulse(input emstat_pkg::emstat_evt_t e, input int n);
    @(posedge clk_sys);
    mac_events <= e;
    repeat (n) @(posedge clk_sys);
    mac_events <= '0;
  endtask

  // Move the live descriptor pointers of the three rings
  task automatic move(input emstat_pkg::emstat_ring_t r);
    @(posedge clk_sys);
    ring_pointers <= r;
  endtask
endmodule // emstat_mac_model

// ===== verification/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  emstat_pkg::emstat_addr_t address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] readdata;
  logic waitrequest;
  emstat_pkg::emstat_evt_t mac_events;
  emstat_pkg::emstat_ring_t ring_pointers;
  logic [1:0] wake_frame_select;
  logic [emstat_pkg::N_FRAMES*32-1:0] wake_mask_words;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  logic [31:0] cnt [12];
  logic [15:0] any_fail;
  logic [7:0] ro [13] = '{8'h90, 8'h94, 8'h98, 8'ha0, 8'ha4, 8'ha8, 8'hac, 8'hb0, 8'hb4,
                          8'hb8, 8'hbc, 8'hc0, 8'hfc};

  // Clock at 250 MHz
  always #2 clk_sys = ~clk_sys;

  emstat_top emstat_top_i (.clk_sys(clk_sys), .reset_n(reset_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .mac_events(mac_events),
    .ring_pointers(ring_pointers), .wake_frame_select(wake_frame_select),
    .wake_mask_words(wake_mask_words));

  emstat_mac_model emstat_mac_model_i (.clk_sys(clk_sys), .mac_events(mac_events),
    .ring_pointers(ring_pointers));

  // Compare one value and log a mismatch
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One Avalon access; the request stands until waitrequest is sampled low
  // Only the bench timeout ends a wait that never gets an answer
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    @(posedge clk_sys);
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= ~wr;
    write <= wr;
    do begin
      @(posedge clk_sys);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'h0, q);
    check(q, exp, $sformatf("read of %h", a));
  endtask

  // Reset for six cycles and clear the expected counts
  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    foreach (cnt[i]) cnt[i] = 32'h0;
    any_fail = 16'h0;
  endtask

  // Fire outcome pulses for n cycles and track the expected counts
  task automatic fire(input logic [11:0] e, input int n);
    emstat_mac_model_i.pulse(e, n);
    for (int i = 0; i < 12; i++) if (e[i]) cnt[i] += 32'(n);
    if (|e[8:6]) any_fail += 16'(n);
  endtask

  // Read every counter register against the expected counts
  task automatic check_counters();
    rdc(8'ha0, cnt[0]);
    rdc(8'ha4, {cnt[4][15:0], cnt[5][15:0]});
    rdc(8'ha8, {any_fail, cnt[6][15:0]});
    rdc(8'hac, {cnt[7][15:0], cnt[8][15:0]});
    rdc(8'hb0, cnt[1]);
    rdc(8'hb4, cnt[2]);
    rdc(8'hb8, cnt[3]);
    rdc(8'hbc, {cnt[9][15:0], cnt[10][15:0]});
    rdc(8'hc0, {16'h0000, cnt[11][15:0]});
  endtask

  // Writes of all ones to read-only and unmapped places change nothing
  task automatic t_idle();
    foreach (ro[i]) wr(ro[i], 32'hffff_ffff, 4'hf);
    foreach (ro[i]) rdc(ro[i], 32'h0);
    $display("test idle done");
  endtask

  // Each outcome alone, then three failures in the same cycle
  task automatic t_events();
    for (int i = 0; i < 12; i++) fire(12'h001 << i, i + 1);
    fire(12'h1c0, 2);
    check_counters();
    $display("test events done");
  endtask

  // Two 16-bit counters (single collision and runt) pass their top value and wrap
  task automatic t_wrap();
    fire(12'h820, 65536);
    check_counters();
    $display("test wrap done");
  endtask

  // Ring pointers are shown as they move
  task automatic t_ring();
    emstat_mac_model_i.move({32'h1000_0010, 32'h2000_0020, 32'h3000_0030});
    repeat (3) @(posedge clk_sys);
    rdc(8'h90, 32'h1000_0010);
    rdc(8'h94, 32'h2000_0020);
    rdc(8'h98, 32'h3000_0030);
    $display("test ring done");
  endtask

  // Four mask banks steered by frame select, edge bits set in each
  task automatic t_wake();
    logic [31:0] exp_mask;
    for (int f = 0; f < 4; f++) begin
      wr(8'hd0, 32'(f), 4'h1);
      wr(8'h8c, 32'h8000_0001 | (32'(f) << 12), 4'hf);
    end
    // Lane 1 write to frame 3 replaces only bits 15:8 of its copy
    wr(8'h8c, 32'h0000_5500, 4'h2);
    for (int f = 0; f < 4; f++) begin
      exp_mask = (f == 3) ? 32'h8000_5501 : (32'h8000_0001 | (32'(f) << 12));
      wr(8'hd0, 32'(f), 4'h1);
      rdc(8'hd0, 32'(f));
      check(32'(wake_frame_select), 32'(f), "frame select");
      rdc(8'h8c, exp_mask);
      check(wake_mask_words[32*f+:32], exp_mask, "mask bank");
    end
    $display("test wake done");
  endtask

  // Reset in mid-run clears counters and mask banks
  task automatic t_rerun();
    do_reset();
    check(wake_mask_words[31:0] | wake_mask_words[63:32] | wake_mask_words[95:64]
          | wake_mask_words[127:96], 32'h0, "mask after reset");
    check_counters();
    rdc(8'h8c, 32'h0);
    $display("test rerun done");
  endtask

  // Print the counts and the verdict, then stop
  task automatic results();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Cut a hang short
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 80000) begin
      fail_count++;
      $display("unexpected at %0t: run took too long", $time);
      results();
    end
  end

  // Main sequence
  initial begin
    do_reset();
    t_idle();
    t_events();
    t_wrap();
    t_ring();
    t_wake();
    t_rerun();
    results();
  end
endmodule // tb
